// ### src/scim_top.v
// Purpose: Safe input cross monitor with pulsed supplies, process image and Avalon-MM registers.
// Assumes: clk_sys at 20 MHz; safe inputs are asynchronous pins; N_INPUTS is even and at most 16.
// Notes: Input 2k is fed from pulsed supply one and input 2k+1 from pulsed supply two.
// Function
// - Each safe input is judged on its own and always against one fixed pulsed supply.
// - With cross monitoring, the first channel of a pair uses supply one, the second supply two.
// - An input reads as zero in the process image when its level is low or it has a fault.
// - An input reads as one only while its level is high and no fault is present.
// - Cross faults are only flagged while cross monitoring is enabled for the pair.
// - A cross fault holds the input at zero until the fault is gone and software acknowledges it.
// - A broken sensor line on a high input shows as a fall to zero with a drop event in the interrupt status, but no fault.
// - Two shorted inputs on different supplies are flagged as a cross fault within 64 ms.
// - After a low phase, a high is reported at the next period end, only once a valid pulse pattern has been seen if cross monitoring is on.
//
// The register offsets and register access over Avalon-MM are this design's own decisions.
`timescale 1ns/10ps
`include "scim_regs.vh"
module scim_top #(
	parameter N_INPUTS      = 8,
	parameter PERIOD_CYCLES = `SCIM_PULSE_PERIOD_CYC,
	parameter WIDTH_CYCLES  = `SCIM_PULSE_WIDTH_CYC,
	parameter CW            = 24
) (
	input  wire                clk_sys,
	input  wire                reset_n,
	input  wire [N_INPUTS-1:0] safe_input,
	output wire                pulsed_supply_one,
	output wire                pulsed_supply_two,
	output reg  [N_INPUTS-1:0] process_image,
	output reg                 irq,
	input  wire [5:0]          avs_address,
	input  wire                avs_read,
	input  wire                avs_write,
	input  wire [31:0]         avs_writedata,
	output reg  [31:0]         avs_readdata,
	output reg                 avs_waitrequest
);
	localparam NP = N_INPUTS / 2;
	localparam NI = 2 * N_INPUTS;
	localparam [31:0] CTRL_RST = `SCIM_CTRL_RST;
	localparam [31:0] MASK_RST = `SCIM_IRQ_MASK_RST;

	reg  [N_INPUTS-1:0] sync_a;
	reg  [N_INPUTS-1:0] sync_b;
	reg  [NP-1:0]       cross_en;
	reg  [NI-1:0]       irq_status;
	reg  [NI-1:0]       irq_mask;
	reg  [15:0]         fault_cnt;
	reg  [31:0]         next_readdata;
	reg  [NI-1:0]       next_irq_status;

	wire                samp_one;
	wire                samp_two;
	wire                period_end;
	wire                quiet;
	wire [N_INPUTS-1:0] chan_bit;
	wire [N_INPUTS-1:0] chan_fault;
	wire [N_INPUTS-1:0] chan_fault_set;
	wire [N_INPUTS-1:0] chan_drop;
	wire [N_INPUTS-1:0] chan_bad;
	wire [N_INPUTS-1:0] ack_vec;

	// A transfer completes on the edge where the master sees waitrequest low.
	wire                wr_fire = avs_write & ~avs_waitrequest;
	wire                ack_hit = wr_fire & (avs_address == `SCIM_OFS_ACK);
	wire                clr_hit = wr_fire & (avs_address == `SCIM_OFS_IRQ_STAT);
	wire [NI-1:0]       irq_events;

	assign ack_vec    = ack_hit ? avs_writedata[N_INPUTS-1:0] : {N_INPUTS{1'b0}};
	assign irq_events = {chan_drop, chan_fault_set};

	// Pins are asynchronous; the first stage feeds only the second.
	always @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			sync_a <= {N_INPUTS{1'b0}};
			sync_b <= {N_INPUTS{1'b0}};
		end else begin
			sync_a <= safe_input;
			sync_b <= sync_a;
		end
	end

	scim_pulse #(
		.PERIOD_CYCLES (PERIOD_CYCLES),
		.WIDTH_CYCLES  (WIDTH_CYCLES),
		.CW            (CW)
	) u_pulse (
		.clk_sys           (clk_sys),
		.reset_n           (reset_n),
		.pulsed_supply_one (pulsed_supply_one),
		.pulsed_supply_two (pulsed_supply_two),
		.samp_one          (samp_one),
		.samp_two          (samp_two),
		.period_end        (period_end),
		.quiet             (quiet)
	);

	genvar i;
	generate
		for (i = 0; i < N_INPUTS; i = i + 1) begin : g_chan
			// The supply of each input is fixed by its position within the pair.
			wire own_end = (i % 2 == 0) ? samp_one : samp_two;
			wire oth_end = (i % 2 == 0) ? samp_two : samp_one;
			scim_chan u_chan (
				.clk_sys     (clk_sys),
				.reset_n     (reset_n),
				.in_level    (sync_b[i]),
				.own_end     (own_end),
				.oth_end     (oth_end),
				.period_end  (period_end),
				.quiet       (quiet),
				.cross_en    (cross_en[i / 2]),
				.ack         (ack_vec[i]),
				.process_bit (chan_bit[i]),
				.fault       (chan_fault[i]),
				.fault_set   (chan_fault_set[i]),
				.drop        (chan_drop[i]),
				.bad_pending (chan_bad[i])
			);
		end
	endgenerate

	// The process image is a plain copy of the channel results, one flop per input.
	always @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n)
			process_image <= {N_INPUTS{1'b0}};
		else
			process_image <= chan_bit;
	end

	// Read mux; unmapped offsets read as zero and ignore writes.
	always @* begin
		next_readdata = 32'h00000000;
		case (avs_address)
			`SCIM_OFS_CTRL: begin
				next_readdata[NP-1:0] = cross_en;
			end
			`SCIM_OFS_STATE: begin
				next_readdata[N_INPUTS-1:0] = process_image;
			end
			`SCIM_OFS_FAULT: begin
				next_readdata[N_INPUTS-1:0] = chan_fault;
			end
			`SCIM_OFS_IRQ_STAT: begin
				next_readdata[NI-1:0] = irq_status;
			end
			`SCIM_OFS_IRQ_MASK: begin
				next_readdata[NI-1:0] = irq_mask;
			end
			`SCIM_OFS_RAW: begin
				next_readdata[N_INPUTS-1:0] = sync_b;
			end
			`SCIM_OFS_PATTERN: begin
				next_readdata[N_INPUTS-1:0] = chan_bad;
			end
			`SCIM_OFS_FAULT_CNT: begin
				next_readdata[15:0] = fault_cnt;
			end
			default: begin
				next_readdata = 32'h00000000;
			end
		endcase
	end

	// One wait state per access keeps readdata registered and stable at the taking edge.
	always @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			avs_waitrequest <= 1'b1;
			avs_readdata    <= 32'h00000000;
		end else if (!avs_waitrequest) begin
			avs_waitrequest <= 1'b1;
		end else if (avs_read | avs_write) begin
			avs_waitrequest <= 1'b0;
			avs_readdata    <= avs_read ? next_readdata : 32'h00000000;
		end
	end

	// Cross monitoring enable per pair and interrupt mask.
	always @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			cross_en <= CTRL_RST[NP-1:0];
			irq_mask <= MASK_RST[NI-1:0];
		end else if (wr_fire) begin
			if (avs_address == `SCIM_OFS_CTRL)
				cross_en <= avs_writedata[NP-1:0];
			if (avs_address == `SCIM_OFS_IRQ_MASK)
				irq_mask <= avs_writedata[NI-1:0];
		end
	end

	// New events win over a write-one-to-clear in the same cycle.
	always @* begin
		next_irq_status = irq_status;
		if (clr_hit)
			next_irq_status = next_irq_status & ~avs_writedata[NI-1:0];
		next_irq_status = next_irq_status | irq_events;
	end

	always @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			irq_status <= {NI{1'b0}};
			irq        <= 1'b0;
		end else begin
			irq_status <= next_irq_status;
			irq        <= |(next_irq_status & irq_mask);
		end
	end

	// Saturating count of cycles in which at least one new cross fault was raised.
	always @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n)
			fault_cnt <= 16'h0000;
		else if (|chan_fault_set && fault_cnt != 16'hffff)
			fault_cnt <= fault_cnt + 16'h0001;
	end
endmodule // scim_top

// ### include/scim_regs.vh
// Purpose: Register map, reset values and timing counts of the safe input cross monitor.
// Assumes: 32-bit Avalon-MM slave with byte addresses, one word per register.
// Notes: Timing counts are derived from the clock rate and the printed times.
`ifndef SCIM_REGS_VH
`define SCIM_REGS_VH

`define SCIM_OFS_CTRL        6'h00
`define SCIM_OFS_STATE       6'h04
`define SCIM_OFS_FAULT       6'h08
`define SCIM_OFS_ACK         6'h0c
`define SCIM_OFS_IRQ_STAT    6'h10
`define SCIM_OFS_IRQ_MASK    6'h14
`define SCIM_OFS_RAW         6'h18
`define SCIM_OFS_PATTERN     6'h1c
`define SCIM_OFS_FAULT_CNT   6'h20

`define SCIM_CTRL_RST        32'h0000000f
`define SCIM_IRQ_MASK_RST    32'h00000000
`define SCIM_IRQ_FAULT_LSB   0
`define SCIM_IRQ_DROP_LSB    8

`define SCIM_CLK_KHZ         20000
`define SCIM_PULSE_PERIOD_US 2000
`define SCIM_PULSE_WIDTH_US  200
`define SCIM_PULSE_PERIOD_CYC (`SCIM_PULSE_PERIOD_US * `SCIM_CLK_KHZ / 1000)
`define SCIM_PULSE_WIDTH_CYC (`SCIM_PULSE_WIDTH_US * `SCIM_CLK_KHZ / 1000)
`define SCIM_CROSS_DETECT_MS 64
`define SCIM_CROSS_DETECT_CYC (`SCIM_CROSS_DETECT_MS * `SCIM_CLK_KHZ)
`define SCIM_CROSS_CONFIRM_LAST 2'h1

`endif

// ### src/scim_pulse.v
// Purpose: Drives the two pulsed supply outputs and marks the sampling points of each period.
// Assumes: WIDTH_CYCLES is at least 4 so that the synchronised input settles inside a pulse.
// Notes: Supply one pulses low from the start of the second quarter, supply two from the start of the fourth quarter.
`timescale 1ns/10ps
module scim_pulse #(
	parameter PERIOD_CYCLES = 40000,
	parameter WIDTH_CYCLES  = 4000,
	parameter CW            = 24
) (
	input  wire clk_sys,
	input  wire reset_n,
	output reg  pulsed_supply_one,
	output reg  pulsed_supply_two,
	output reg  samp_one,
	output reg  samp_two,
	output reg  period_end,
	output reg  quiet
);
	localparam integer  P_LAST_I  = PERIOD_CYCLES - 1;
	localparam integer  A_START_I = PERIOD_CYCLES / 4;
	localparam integer  A_END_I   = PERIOD_CYCLES / 4 + WIDTH_CYCLES;
	localparam integer  B_START_I = (PERIOD_CYCLES / 4) * 3;
	localparam integer  B_END_I   = (PERIOD_CYCLES / 4) * 3 + WIDTH_CYCLES;
	// The integer points are cut to the counter width on purpose; CW must hold a period.
	localparam [CW-1:0] P_LAST    = P_LAST_I[CW-1:0];
	localparam [CW-1:0] A_START   = A_START_I[CW-1:0];
	localparam [CW-1:0] A_END     = A_END_I[CW-1:0];
	localparam [CW-1:0] B_START   = B_START_I[CW-1:0];
	localparam [CW-1:0] B_END     = B_END_I[CW-1:0];

	reg  [CW-1:0] cnt;
	reg  [2:0]    hist;
	wire          in_one = (cnt >= A_START) && (cnt < A_END);
	wire          in_two = (cnt >= B_START) && (cnt < B_END);
	wire          busy   = ~pulsed_supply_one | ~pulsed_supply_two;

	always @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			cnt               <= {CW{1'b0}};
			pulsed_supply_one <= 1'b1;
			pulsed_supply_two <= 1'b1;
			samp_one          <= 1'b0;
			samp_two          <= 1'b0;
			period_end        <= 1'b0;
			hist              <= 3'h0;
			quiet             <= 1'b0;
		end else begin
			cnt               <= (cnt == P_LAST) ? {CW{1'b0}} : cnt + 1'b1;
			pulsed_supply_one <= ~in_one;
			pulsed_supply_two <= ~in_two;
			samp_one          <= (cnt == A_END - 1'b1);
			samp_two          <= (cnt == B_END - 1'b1);
			period_end        <= (cnt == P_LAST);
			// The input lags the pins by the synchroniser, so quiet waits out that tail.
			hist              <= {hist[1:0], busy};
			quiet             <= ~(|{hist, busy});
		end
	end
endmodule // scim_pulse

// ### src/scim_chan.v
// Purpose: Evaluates one single-channel safe input against its assigned pulsed supply.
// Assumes: in_level is already synchronised; strobes come from scim_pulse.
// Notes: own_end marks the assigned supply's pulse, oth_end the other supply's pulse.
`timescale 1ns/10ps
`include "scim_regs.vh"
module scim_chan (
	input  wire clk_sys,
	input  wire reset_n,
	input  wire in_level,
	input  wire own_end,
	input  wire oth_end,
	input  wire period_end,
	input  wire quiet,
	input  wire cross_en,
	input  wire ack,
	output reg  process_bit,
	output reg  fault,
	output reg  fault_set,
	output reg  drop,
	output wire bad_pending
);
	reg  [1:0] bad_cnt;
	reg        own_smp;
	reg        oth_smp;
	reg        next_report;
	// A valid pattern follows the own supply: low in its pulse, high in the other's.
	wire       own_pattern = ~own_smp & oth_smp;
	wire       bad_pattern = cross_en & in_level & ~own_pattern;
	wire       good_high   = in_level & (~cross_en | own_pattern);
	wire       set_now     = period_end & bad_pattern & (bad_cnt == `SCIM_CROSS_CONFIRM_LAST);
	// An acknowledge is refused while the last period still showed a bad pattern.
	wire       clr_now     = ack & (bad_cnt == 2'h0) & ~set_now;
	wire       next_fault  = set_now | (fault & ~clr_now);

	assign bad_pending = (bad_cnt != 2'h0);

	always @* begin
		next_report = process_bit;
		if (next_fault)
			next_report = 1'b0;
		else if (quiet & ~in_level)
			next_report = 1'b0;
		else if (period_end)
			next_report = good_high;
	end

	always @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			own_smp     <= 1'b1;
			oth_smp     <= 1'b0;
			bad_cnt     <= 2'h0;
			fault       <= 1'b0;
			fault_set   <= 1'b0;
			process_bit <= 1'b0;
			drop        <= 1'b0;
		end else begin
			if (own_end)
				own_smp <= in_level;
			if (oth_end)
				oth_smp <= in_level;
			if (period_end)
				bad_cnt <= bad_pattern ? ((bad_cnt == 2'h3) ? 2'h3 : bad_cnt + 2'h1) : 2'h0;
			fault       <= next_fault;
			fault_set   <= set_now;
			process_bit <= next_report;
			drop        <= process_bit & ~next_report;
		end
	end
endmodule // scim_chan

// ### sim/scim_sensor.sv
// Purpose: Sensor contacts of the safe inputs, fed from the two pulsed supplies.
// Assumes: Every input has a pull-down, so an open contact or a broken line reads low.
// Notes: swap feeds an input from the wrong supply, which is how a cross short looks.
`timescale 1ns/10ps
module scim_sensor #(
	parameter N = 8
) (
	input  wire         sup_one,
	input  wire         sup_two,
	input  wire [N-1:0] closed,
	input  wire [N-1:0] swap,
	output wire [N-1:0] pins
);
	genvar i;
	for (i = 0; i < N; i = i + 1) begin : g_pin
		assign pins[i] = closed[i] & ((((i % 2) == 1) ^ swap[i]) ? sup_two : sup_one);
	end
endmodule // scim_sensor

// ### sim/scim_top_sva.sv
// Purpose: Port-level assertions for the safe input cross monitor.
// Assumes: Bound to scim_top; a single clock domain.
// Notes: Image checks only look where the pin cannot be inside a test pulse.
`timescale 1ns/10ps
module scim_top_sva #(
	parameter N_INPUTS      = 8,
	parameter PERIOD_CYCLES = 40000,
	parameter WIDTH_CYCLES  = 4000
) (
	input wire                clk_sys,
	input wire                reset_n,
	input wire [N_INPUTS-1:0] safe_input,
	input wire                pulsed_supply_one,
	input wire                pulsed_supply_two,
	input wire [N_INPUTS-1:0] process_image,
	input wire                avs_read,
	input wire                avs_write,
	input wire                avs_waitrequest
);
	localparam int HALF = PERIOD_CYCLES / 2;
	localparam int WL   = WIDTH_CYCLES - 1;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!reset_n);
	sequence s_req_open;
		(avs_read || avs_write) && avs_waitrequest;
	endsequence
	// Both supplies high for eight cycles keeps the sync delay after a pulse out of view.
	sequence s_quiet_low(logic pin);
		(pulsed_supply_one && pulsed_supply_two && !pin)[*8];
	endsequence
	a_req_answered: assert property (s_req_open |=> !avs_waitrequest)
		else $error("bus request not answered in the next cycle");
	a_wait_one_cycle: assert property (!avs_waitrequest |=> avs_waitrequest)
		else $error("waitrequest low for more than one cycle");
	a_supplies_apart: assert property (pulsed_supply_one || pulsed_supply_two)
		else $error("both supplies pulsed at once");
	a_pulse_width: assert property ($fell(pulsed_supply_one) |-> ##WL !pulsed_supply_one ##1 pulsed_supply_one)
		else $error("supply one pulse width wrong");
	a_one_to_two: assert property ($fell(pulsed_supply_one) |-> ##HALF $fell(pulsed_supply_two))
		else $error("supply two pulse not half a period after supply one");
	a_two_to_one: assert property ($fell(pulsed_supply_two) |-> ##HALF $fell(pulsed_supply_one))
		else $error("supply one pulse not half a period after supply two");
	genvar k;
	for (k = 0; k < N_INPUTS; k = k + 1) begin : g_in
		a_low_drops: assert property (s_quiet_low(safe_input[k]) |-> ##[0:8] !process_image[k])
			else $error("image stays high on a low input");
		a_rise_cause: assert property ($rose(process_image[k]) |-> $past(safe_input[k], 4))
			else $error("image rose without a high input");
	end
endmodule // scim_top_sva

// ### sim/scim_top_tb.sv
// Purpose: Self-checking bench of the safe input cross monitor.
// Assumes: Shortened pulse period of 400 cycles with 40-cycle pulses.
// Notes: Fixed waits are whole periods except the 12-cycle reset wait and one 10-cycle wait, since the image only rises at period ends.
`timescale 1ns/10ps
module scim_top_tb;
	localparam int P = 400;
	logic        clk_sys;
	logic        reset_n;
	logic [7:0]  closed;
	logic [7:0]  swap;
	wire  [7:0]  safe_input;
	wire         sup_one;
	wire         sup_two;
	wire  [7:0]  image;
	wire         irq;
	logic [5:0]  avs_address;
	logic        avs_read;
	logic        avs_write;
	logic [31:0] avs_writedata;
	wire  [31:0] avs_readdata;
	wire         avs_waitrequest;
	logic [31:0] rd;
	int          n_errors;
	int          total_checks;

	scim_top #(.PERIOD_CYCLES(P), .WIDTH_CYCLES(40)) u_dut (.clk_sys(clk_sys),
		.reset_n(reset_n), .safe_input(safe_input), .pulsed_supply_one(sup_one),
		.pulsed_supply_two(sup_two), .process_image(image), .irq(irq),
		.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest));
	scim_sensor #(.N(8)) u_sensor (.sup_one(sup_one), .sup_two(sup_two), .closed(closed),
		.swap(swap), .pins(safe_input));

	always #25 clk_sys = ~clk_sys;

	task print_verdict;
		$display("checks %0d errors %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask

	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		total_checks++;
		if (g !== e) begin
			n_errors++;
			$display("[ERR] %s exp %h got %h", nm, e, g);
		end
	endtask

	// Request is held until waitrequest is seen low at a rising edge.
	task bus(input logic w, input logic [5:0] a, input logic [31:0] d);
		int k;
		@(posedge clk_sys);
		avs_address <= a;
		avs_write <= w;
		avs_read <= !w;
		avs_writedata <= d;
		k = 0;
		do begin
			@(posedge clk_sys);
			k++;
		end while (avs_waitrequest !== 1'b0 && k < 20);
		rd = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		if (avs_waitrequest !== 1'b0) begin
			n_errors++;
			$display("[ERR] waitrequest exp 0 got %b", avs_waitrequest);
			print_verdict();
		end
	endtask

	task rchk(input string nm, input logic [5:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		chk(nm, e, rd);
	endtask

	task periods(input int n);
		repeat (n * P) @(posedge clk_sys);
	endtask

	task s_regs;
		rchk("ctrl", 6'h00, 32'h0000000f);
		rchk("mask", 6'h14, 32'h00000000);
		bus(1'b1, 6'h3c, 32'hffffffff);
		rchk("unmapped", 6'h3c, 32'h00000000);
	endtask

	task s_high;
		periods(3);
		chk("image", 32'h000000ff, {24'h0, image});
		rchk("state", 6'h04, 32'h000000ff);
		rchk("fault", 6'h08, 32'h00000000);
	endtask

	task s_break;
		closed <= 8'hfe;
		periods(1);
		chk("image", 32'h000000fe, {24'h0, image});
		rchk("fault", 6'h08, 32'h00000000);
		rchk("stat", 6'h10, 32'h00000100);
		chk("irq", 32'h0, {31'h0, irq});
		bus(1'b1, 6'h10, 32'h00000100);
		rchk("stat", 6'h10, 32'h00000000);
		closed <= 8'hff;
		repeat (10) @(posedge clk_sys);
		chk("image", 32'h000000fe, {24'h0, image});
		periods(3);
		chk("image", 32'h000000ff, {24'h0, image});
	endtask

	task s_cross;
		bus(1'b1, 6'h14, 32'h000000ff);
		swap <= 8'h04;
		periods(4);
		rchk("fault", 6'h08, 32'h00000004);
		chk("image", 32'h000000fb, {24'h0, image});
		chk("irq", 32'h1, {31'h0, irq});
		rchk("stat", 6'h10, 32'h00000404);
		rchk("pattern", 6'h1c, 32'h00000004);
		bus(1'b1, 6'h0c, 32'h00000004);
		periods(1);
		chk("image", 32'h000000fb, {24'h0, image});
		swap <= 8'h00;
		periods(2);
		chk("image", 32'h000000fb, {24'h0, image});
		bus(1'b1, 6'h0c, 32'h00000004);
		bus(1'b1, 6'h10, 32'h0000ffff);
		periods(2);
		chk("image", 32'h000000ff, {24'h0, image});
		rchk("fault", 6'h08, 32'h00000000);
		chk("irq", 32'h0, {31'h0, irq});
		rchk("fault_cnt", 6'h20, 32'h00000001);
	endtask

	task s_cross_off;
		bus(1'b1, 6'h00, 32'h0000000e);
		swap <= 8'h01;
		periods(4);
		chk("image", 32'h000000ff, {24'h0, image});
		rchk("fault", 6'h08, 32'h00000000);
		rchk("fault_cnt", 6'h20, 32'h00000001);
		swap <= 8'h00;
		bus(1'b1, 6'h00, 32'h0000000f);
	endtask

	initial begin
		clk_sys = 1'b0;
		reset_n = 1'b0;
		closed = 8'hff;
		swap = 8'h00;
		avs_address = 6'h00;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = 32'h0;
		n_errors = 0;
		total_checks = 0;
		repeat (12) @(posedge clk_sys);
		reset_n <= 1'b1;
		s_regs();
		s_high();
		s_break();
		s_cross();
		s_cross_off();
		print_verdict();
	end
endmodule // scim_top_tb

bind scim_top scim_top_sva #(.N_INPUTS(N_INPUTS), .PERIOD_CYCLES(PERIOD_CYCLES),
	.WIDTH_CYCLES(WIDTH_CYCLES)) u_sva (.clk_sys(clk_sys), .reset_n(reset_n),
	.safe_input(safe_input), .pulsed_supply_one(pulsed_supply_one),
	.pulsed_supply_two(pulsed_supply_two), .process_image(process_image),
	.avs_read(avs_read), .avs_write(avs_write), .avs_waitrequest(avs_waitrequest));
